// ---- bench/ebsc_ext_mem.sv ----
// Behavioural external memory on the far side of the strobe controller
`timescale 1ns/1ps
module ebsc_ext_mem (
  input wire clk,
  input wire io_space_select_b,
  input wire data_space_select_b,
  input wire program_space_select_b,
  input wire write_strobe_b,
  input wire read_strobe_b,
  input wire [15:0] data_out,
  input wire slow,
  output logic ready_in,
  output logic [15:0] data_in
);
  logic [15:0] mem [0:2];
  logic [1:0] sp;
  int hold = 0;
  assign sp = !program_space_select_b ? 2'h0 : (!data_space_select_b ? 2'h1 : 2'h2);
  initial ready_in = 1'b1;
  initial data_in = 16'h0000;
  wire any_sel = !(io_space_select_b && data_space_select_b && program_space_select_b);
  // One word per space, written at the strobe
  always @(posedge clk) begin
    if (!write_strobe_b) mem[sp] <= data_out;
    hold <= any_sel ? hold + 1 : 0;
    ready_in <= !(slow && hold < 6);
  end
  // Selected word driven by mid-cycle; a released bus shows the inverse
  always @(negedge clk) begin
    data_in <= any_sel ? mem[sp] : ~data_in;
  end
endmodule // ebsc_ext_mem

// ---- bench/ebsc_monitor.sv ----
// Checker for the external bus strobe controller pins
`timescale 1ns/1ps
module ebsc_monitor (
  input wire clk,
  input wire rst_b,
  input wire req_done,
  input wire req_illegal,
  input wire io_space_select_b,
  input wire data_space_select_b,
  input wire program_space_select_b,
  input wire space_select_oe,
  input wire write_strobe_b,
  input wire write_strobe_oe,
  input wire read_strobe_b,
  input wire rw_dir,
  input wire rw_dir_oe,
  input wire external_cycle_strobe_b,
  input wire global_memory_request_b,
  input wire global_memory_request_oe,
  input wire emulator_float_input_b,
  input wire trace_mode,
  input wire trace_clock,
  input wire cpu_clock_output,
  input wire set_flag_instruction,
  input wire flag_pin_gpio_sel,
  input wire flag_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_ONE_SEL: assert property (
    $onehot0(~{io_space_select_b, data_space_select_b, program_space_select_b}))
    else $error("several selects low");
  AST_WR: assert property (!write_strobe_b |-> !rw_dir && !external_cycle_strobe_b)
    else $error("write strobe outside write cycle");
  AST_RD: assert property (!read_strobe_b |-> rw_dir && !external_cycle_strobe_b)
    else $error("read strobe outside read cycle");
  AST_CYC_SEL: assert property (
    !external_cycle_strobe_b |-> !(io_space_select_b && data_space_select_b
    && program_space_select_b)) else $error("cycle without select");
  AST_GLB: assert property (!global_memory_request_b |-> !data_space_select_b)
    else $error("global request outside data space");
  AST_DONE: assert property (req_done |-> !external_cycle_strobe_b)
    else $error("done without strobe");
  AST_ILL: assert property (req_illegal |-> ##[0:3] external_cycle_strobe_b)
    else $error("illegal access strobed");
  AST_FLT: assert property (!emulator_float_input_b [*6] |-> !space_select_oe
    && !write_strobe_oe && !rw_dir_oe && !global_memory_request_oe)
    else $error("pins driven while floated");
  AST_TRC: assert property (!trace_mode [*2] |-> !trace_clock)
    else $error("trace clock runs with trace off");
  AST_TRC_PH: assert property (trace_clock |-> cpu_clock_output)
    else $error("trace clock out of phase");
  AST_FLAG: assert property (
    set_flag_instruction && !flag_pin_gpio_sel |-> ##[1:2] flag_output)
    else $error("flag not set");
  AST_RST: assert property ($rose(rst_b) |-> trace_mode && !flag_output)
    else $error("wrong state after reset");
  // Main scenarios seen
  cover property (!write_strobe_b);
  cover property (!read_strobe_b);
  cover property (req_illegal);
endmodule // ebsc_monitor

bind ebsc_ctrl ebsc_monitor i_mon (.*);

// ---- bench/tb_external_bus_strobe_control.sv ----
// Self-checking testbench for the external bus strobe controller
`timescale 1ns/1ps
module tb_external_bus_strobe_control;
  logic clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_global = 1'b0;
  logic [1:0] req_space = 2'h0;
  logic [2:0] wait_states = 3'h0;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, data_in, data_out;
  logic power_down = 1'b0, trace_mode_set = 1'b0, trace_mode_clear = 1'b0, slow = 1'b0;
  logic set_flag_instruction = 1'b0, clear_flag_instruction = 1'b0, flag_pin_gpio_sel = 1'b0;
  logic flag_gpio_out = 1'b0, branch_pin_gpio_sel = 1'b0, conditional_branch_instruction = 1'b0;
  logic emulator_float_input_b = 1'b1, external_interface_enable = 1'b1;
  logic branch_test_input_b = 1'b1, ready_in, req_ready, req_done, req_illegal, trace_mode;
  logic branch_taken, branch_valid, io_space_select_b, data_space_select_b;
  logic program_space_select_b, space_select_oe, write_strobe_b, write_strobe_oe;
  logic read_strobe_b, read_strobe_oe, rw_dir, rw_dir_oe, external_cycle_strobe_b;
  logic external_cycle_strobe_oe, global_memory_request_b, global_memory_request_oe;
  logic data_oe, cpu_clock_output, trace_clock, trace_bus_output_indicator_b;
  logic flag_output, flag_output_oe;
  int fails = 0, cmp_count = 0, n;
  ebsc_ctrl i_dut (.*);
  ebsc_ext_mem i_mem (.*);
  always #12.5 clk = ~clk;
  task tick(input int k);
    repeat (k) begin @(posedge clk); #1; end
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin fails++; $display("FAIL %0t got %h exp %h", $time, got, exp); end
  endtask
  // One access: wait idle, present, count edges to the answer
  task acc(input logic w, input logic [1:0] sp, input logic g, input logic [15:0] d);
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin tick(1); n++; end
    req_write = w; req_space = sp; req_global = g; req_wdata = d; req_valid = 1'b1;
    tick(1);
    req_valid = 1'b0;
    n = 0;
    while (req_done !== 1'b1 && req_illegal !== 1'b1 && n < 40) begin tick(1); n++; end
    if (n >= 40) begin fails++; $display("FAIL %0t access timeout", $time); end
  endtask
  task t_rw;
    for (int s = 0; s < 3; s++) begin
      acc(1'b1, 2'(s), 1'b0, 16'hA5C0 + 16'(s));
      chk(16'(n), 16'h0002);
      acc(1'b0, 2'(s), 1'b0, 16'h0000);
      chk(rsp_rdata, 16'hA5C0 + 16'(s));
    end
    wait_states = 3'h3;
    acc(1'b1, 2'h1, 1'b1, 16'h3C5A);
    chk(16'(n), 16'h0005);
    slow = 1'b1;
    wait_states = 3'h4;
    acc(1'b0, 2'h1, 1'b0, 16'h0000);
    chk(16'(n > 6), 16'h0001);
    chk(rsp_rdata, 16'h3C5A);
    slow = 1'b0;
    wait_states = 3'h0;
  endtask
  task t_ill;
    acc(1'b0, 2'h3, 1'b0, 16'h0000);
    chk(16'(req_illegal), 16'h0001);
    external_interface_enable = 1'b0;
    tick(5);
    acc(1'b1, 2'h0, 1'b0, 16'h1234);
    chk(16'(req_illegal), 16'h0001);
    external_interface_enable = 1'b1;
    tick(5);
  endtask
  task t_flag;
    set_flag_instruction = 1'b1;
    tick(1);
    set_flag_instruction = 1'b0;
    tick(1);
    chk(16'(flag_output), 16'h0001);
    clear_flag_instruction = 1'b1;
    tick(1);
    clear_flag_instruction = 1'b0;
    tick(1);
    chk(16'(flag_output), 16'h0000);
  endtask
  task t_branch;
    for (int b = 0; b < 2; b++) begin
      branch_test_input_b = b[0];
      tick(5);
      conditional_branch_instruction = 1'b1;
      tick(1);
      conditional_branch_instruction = 1'b0;
      n = 0;
      while (branch_valid !== 1'b1 && n < 10) begin tick(1); n++; end
      if (n >= 10) begin fails++; $display("FAIL %0t branch timeout", $time); end
      chk(16'(branch_taken), 16'(!b[0]));
    end
  endtask
  task t_trace;
    chk(16'({data_oe, trace_bus_output_indicator_b}), 16'h0002);
    trace_mode_clear = 1'b1;
    tick(1);
    trace_mode_clear = 1'b0;
    tick(2);
    chk(16'({trace_mode, trace_clock, trace_bus_output_indicator_b}), 16'h0001);
    trace_mode_set = 1'b1;
    tick(1);
    trace_mode_set = 1'b0;
    tick(2);
    chk(16'(trace_mode), 16'h0001);
  endtask
  task t_float;
    emulator_float_input_b = 1'b0;
    tick(6);
    chk(16'({space_select_oe, write_strobe_oe, read_strobe_oe, rw_dir_oe,
      external_cycle_strobe_oe, global_memory_request_oe}), 16'h0000);
    emulator_float_input_b = 1'b1;
    power_down = 1'b1;
    tick(6);
    chk(16'({space_select_oe, rw_dir_oe, external_cycle_strobe_oe,
      global_memory_request_oe}), 16'h0000);
    power_down = 1'b0;
    tick(6);
  endtask
  task print_verdict;
    $display("fails %0d compares %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence, with a second reset in mid-run
  initial begin
    tick(3);
    chk(16'({space_select_oe, global_memory_request_oe, trace_clock, flag_output,
      trace_mode}), 16'h0001);
    rst_b = 1'b1;
    tick(4);
    t_rw();
    t_ill();
    t_flag();
    t_branch();
    t_trace();
    t_float();
    rst_b = 1'b0;
    tick(1);
    chk(16'({space_select_oe, trace_mode}), 16'h0001);
    rst_b = 1'b1;
    tick(4);
    t_rw();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule // tb_external_bus_strobe_control

// ---- verilog/ebsc_ctrl.v ----
// External bus strobe controller: selects, strobes, flag and branch test pins
// Behaviour
// R1: Each space select high, low only while accessing its external space.
// R2: Space selects float in reset, power down, or emulator float low.
// R3: Write strobe pulses low on each external write; falling edge starts data drive.
// R4: Write strobe active for program, data and I/O writes alike.
// R5: Write strobe floats while emulator float input is low.
// R6: Read strobe asserted for every external read of any space.
// R7: Read strobe floats while emulator float input is low.
// R8: Direction output high for read, low only during external write.
// R9: Direction output floats in power down or emulator float low.
// R10: Cycle strobe high, low during every off-chip access.
// R11: Cycle strobe floats in power down or emulator float low.
// R12: Global memory request asserted during global data memory accesses.
// R13: Global memory request floats in reset, power down or emulator float low.
// R14: Trace clock follows CPU clock output, aligned to bus; low at reset.
// R15: Interface enabled only while enable input high; else access is illegal.
// R16: Trace bus indicator low while data bus drives out in trace mode.
// R17: Flag output latch set and cleared by flag instructions.
// R18: Flag pin returns to flag function on every reset; reset here leaves the pin following flag_pin_gpio_sel.
// R19: Branch test sampled on conditional branch; branch taken when low.
// R20: Branch test pin returns to branch function on every reset; reset here leaves it following branch_pin_gpio_sel.
// R21: Trace mode enabled out of reset.
// R22: Data bus stays in output mode while trace mode enabled. Here emulator float low still floats it.
// R23: With wait states programmed, ready is sampled; low adds a cycle.
// R24: At most one space select asserted per bus cycle.
`timescale 1ns/1ps
`include "ebsc_defines.vh"

module ebsc_ctrl #(
  parameter DATA_W = `EBSC_DATA_W
) (
  input wire clk,
  input wire rst_b,
  // Core access request
  input wire req_valid,
  input wire req_write,
  input wire [1:0] req_space,
  input wire req_global,
  input wire [DATA_W-1:0] req_wdata,
  output reg req_ready,
  output reg req_done,
  output reg req_illegal,
  output reg [DATA_W-1:0] rsp_rdata,
  // Configuration from core
  input wire [2:0] wait_states,
  input wire power_down,
  input wire trace_mode_set,
  input wire trace_mode_clear,
  output reg trace_mode,
  // Flag and branch test control
  input wire set_flag_instruction,
  input wire clear_flag_instruction,
  input wire flag_pin_gpio_sel,
  input wire flag_gpio_out,
  input wire branch_pin_gpio_sel,
  input wire conditional_branch_instruction,
  output reg branch_taken,
  output reg branch_valid,
  // Pins from outside
  input wire emulator_float_input_b,
  input wire external_interface_enable,
  input wire ready_in,
  input wire branch_test_input_b,
  input wire [DATA_W-1:0] data_in,
  // Pins to outside
  output reg io_space_select_b,
  output reg data_space_select_b,
  output reg program_space_select_b,
  output reg space_select_oe,
  output reg write_strobe_b,
  output reg write_strobe_oe,
  output reg read_strobe_b,
  output reg read_strobe_oe,
  output reg rw_dir,
  output reg rw_dir_oe,
  output reg external_cycle_strobe_b,
  output reg external_cycle_strobe_oe,
  output reg global_memory_request_b,
  output reg global_memory_request_oe,
  output reg [DATA_W-1:0] data_out,
  output reg data_oe,
  output reg cpu_clock_output,
  output reg trace_clock,
  output reg trace_bus_output_indicator_b,
  output reg flag_output,
  output reg flag_output_oe
);

  //--------------------------------------------------------------
  // Pin input synchronisers
  //--------------------------------------------------------------
  // Pins are asynchronous to clk; three flops each
  // A new level is taken only once stages two and three agree
  // Costs about four cycles of latency on every pin input
  // Reset values match the idle level of float, ready and branch test; enable resets low
  reg [2:0] sync_float;
  reg [2:0] sync_ena;
  reg [2:0] sync_ready;
  reg [2:0] sync_bio;
  reg float_b;
  reg ena;
  reg rdy;
  reg bio_b;

  // Agreement of second and third stage
  function upd;
    input [2:0] s;
    input cur;
    begin
      upd = (s[1] == s[2]) ? s[2] : cur;
    end
  endfunction

  // Three flops per pin input
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_float <= 3'h7;
      sync_ena <= 3'h0;
      sync_ready <= 3'h7;
      sync_bio <= 3'h7;
      float_b <= 1'b1;
      ena <= 1'b0;
      rdy <= 1'b1;
      bio_b <= 1'b1;
    end else begin
      sync_float <= {sync_float[1:0], emulator_float_input_b};
      sync_ena <= {sync_ena[1:0], external_interface_enable};
      sync_ready <= {sync_ready[1:0], ready_in};
      sync_bio <= {sync_bio[1:0], branch_test_input_b};
      float_b <= upd(sync_float, float_b);
      ena <= upd(sync_ena, ena);
      rdy <= upd(sync_ready, rdy);
      bio_b <= upd(sync_bio, bio_b);
    end
  end

  //--------------------------------------------------------------
  // Bus cycle state machine
  //--------------------------------------------------------------
  // Idle, setup with selects low, strobe with waits, end
  // Pins are registered, so they trail the state by one cycle
  // Ready is ignored when no software wait state is programmed
  localparam ST_IDLE = `EBSC_ST_IDLE;
  localparam ST_SETUP = `EBSC_ST_SETUP;
  localparam ST_STROBE = `EBSC_ST_STROBE;
  localparam ST_END = `EBSC_ST_END;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [2:0] wait_cnt;
  reg cyc_write;
  reg [1:0] cyc_space;
  reg cyc_global;
  reg [DATA_W-1:0] cyc_wdata;
  reg sel_space_valid;

  // Legal space code check
  always @* begin
    sel_space_valid = (req_space == `EBSC_SPACE_PROG) || (req_space == `EBSC_SPACE_DATA) ||
                      (req_space == `EBSC_SPACE_IO);
  end

  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_valid && ena && sel_space_valid) next_state = ST_SETUP; // R15
      end
      ST_SETUP: next_state = ST_STROBE;
      ST_STROBE: begin
        // Ready only sampled once wait states are programmed
        if (wait_cnt == 3'h0 && (wait_states == `EBSC_WAIT_DEFAULT || rdy))
          next_state = ST_END; // R23
      end
      ST_END: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // State, cycle capture and wait counting
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      wait_cnt <= 3'h0;
      cyc_write <= 1'b0;
      cyc_space <= `EBSC_SPACE_PROG;
      cyc_global <= 1'b0;
      cyc_wdata <= {DATA_W{1'b0}};
    end else begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_SETUP) begin
        cyc_write <= req_write;
        cyc_space <= req_space;
        cyc_global <= req_global && (req_space == `EBSC_SPACE_DATA);
        cyc_wdata <= req_wdata;
        wait_cnt <= wait_states;
      end else if (state == ST_STROBE && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end

  //--------------------------------------------------------------
  // Request answers
  //--------------------------------------------------------------
  // Done pulses for one cycle at the last strobe edge
  // Read data taken at that edge, while selects still stand
  // Illegal pulses for one cycle, and no strobe follows
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ready <= 1'b0;
      req_done <= 1'b0;
      req_illegal <= 1'b0;
      rsp_rdata <= {DATA_W{1'b0}};
    end else begin
      req_ready <= (next_state == ST_IDLE);
      req_done <= (state == ST_STROBE) && (next_state == ST_END);
      // Access with interface disabled is illegal
      req_illegal <= (state == ST_IDLE) && req_valid && (!ena || !sel_space_valid); // R15
      if (state == ST_STROBE && next_state == ST_END && !cyc_write)
        rsp_rdata <= data_in;
    end
  end

  //--------------------------------------------------------------
  // Trace mode and power-down float
  //--------------------------------------------------------------
  wire flt_all = !float_b;
  wire flt_pd = flt_all || power_down;
  wire active = (state == ST_SETUP) || (state == ST_STROBE);

  // Trace mode flag; set wins over a clear in the same cycle
  // Power down floats selects, direction, cycle strobe and global request, but not strobes or flag output
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trace_mode <= 1'b1; // R21
    end else if (trace_mode_set) begin
      trace_mode <= 1'b1;
    end else if (trace_mode_clear) begin
      trace_mode <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // Bus strobe pins
  //--------------------------------------------------------------
  // Every pin and its enable come straight from a flop
  // Enables low mean the pad floats; levels still follow the bus cycle meanwhile
  // Selects cover setup and strobe, strobes only the strobe state
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_space_select_b <= 1'b1;
      data_space_select_b <= 1'b1;
      program_space_select_b <= 1'b1;
      space_select_oe <= 1'b0; // R2
      write_strobe_b <= 1'b1;
      write_strobe_oe <= 1'b1;
      read_strobe_b <= 1'b1;
      read_strobe_oe <= 1'b1;
      rw_dir <= 1'b1;
      rw_dir_oe <= 1'b1;
      external_cycle_strobe_b <= 1'b1;
      external_cycle_strobe_oe <= 1'b1;
      global_memory_request_b <= 1'b1;
      global_memory_request_oe <= 1'b0; // R13
      data_out <= {DATA_W{1'b0}};
      data_oe <= 1'b1;
      trace_bus_output_indicator_b <= 1'b0;
    end else begin
      // One decoded select per cycle
      program_space_select_b <= !(active && cyc_space == `EBSC_SPACE_PROG); // R1 R24
      data_space_select_b <= !(active && cyc_space == `EBSC_SPACE_DATA); // R1 R24
      io_space_select_b <= !(active && cyc_space == `EBSC_SPACE_IO); // R1 R24
      space_select_oe <= !flt_pd; // R2
      // Write strobe on any space
      write_strobe_b <= !(state == ST_STROBE && cyc_write); // R3 R4
      write_strobe_oe <= !flt_all; // R5
      read_strobe_b <= !(state == ST_STROBE && !cyc_write); // R6
      read_strobe_oe <= !flt_all; // R7
      rw_dir <= !(active && cyc_write); // R8
      rw_dir_oe <= !flt_pd; // R9
      external_cycle_strobe_b <= !(state == ST_STROBE); // R10
      external_cycle_strobe_oe <= !flt_pd; // R11
      global_memory_request_b <= !(active && cyc_global); // R12
      global_memory_request_oe <= !flt_pd; // R13
      // Drive data from write strobe fall, or throughout trace mode; emulator float low floats it in both cases
      data_out <= cyc_wdata;
      data_oe <= !flt_all && ((state == ST_STROBE && cyc_write) || trace_mode); // R3 R22
      trace_bus_output_indicator_b <= !(trace_mode && !flt_all &&
                                        ((state == ST_STROBE && cyc_write) || trace_mode)); // R16
    end
  end

  //--------------------------------------------------------------
  // CPU and trace clock outputs
  //--------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clock_output <= 1'b0;
      trace_clock <= 1'b0; // R14
    end else begin
      cpu_clock_output <= !cpu_clock_output;
      // Equal to the cpu clock output while tracing, else held low
      // Both come from the same edge, so bus pins change with them
      trace_clock <= trace_mode ? !cpu_clock_output : 1'b0; // R14
    end
  end

  //--------------------------------------------------------------
  // Flag output and branch test
  //--------------------------------------------------------------
  // Set wins over clear in one cycle
  // Reset clears flag and branch outputs; flag_pin_gpio_sel and branch_pin_gpio_sel still pick the pin functions
  // Branch answer trails the instruction by one cycle
  reg flag_latch;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_latch <= 1'b0;
      flag_output <= 1'b0;
      flag_output_oe <= 1'b1;
      branch_taken <= 1'b0;
      branch_valid <= 1'b0;
    end else begin
      if (set_flag_instruction) flag_latch <= 1'b1; // R17
      else if (clear_flag_instruction) flag_latch <= 1'b0; // R17
      // Pin muxed to GPIO only once software selects it
      flag_output <= flag_pin_gpio_sel ? flag_gpio_out :
                     (set_flag_instruction ? 1'b1 :
                      (clear_flag_instruction ? 1'b0 : flag_latch)); // R18
      flag_output_oe <= 1'b1;
      branch_valid <= conditional_branch_instruction && !branch_pin_gpio_sel; // R20
      branch_taken <= conditional_branch_instruction && !branch_pin_gpio_sel && !bio_b; // R19
    end
  end

endmodule // ebsc_ctrl

// ---- verilog/ebsc_defines.vh ----
// Constants for the external bus strobe controller
`ifndef EBSC_DEFINES_VH
`define EBSC_DEFINES_VH
// Space codes on the request port
`define EBSC_SPACE_PROG 2'h0
`define EBSC_SPACE_DATA 2'h1
`define EBSC_SPACE_IO 2'h2
// Bus cycle states
`define EBSC_ST_IDLE 2'h0
`define EBSC_ST_SETUP 2'h1
`define EBSC_ST_STROBE 2'h2
`define EBSC_ST_END 2'h3
// Default software wait states
`define EBSC_WAIT_DEFAULT 3'h0
// Bus data width
`define EBSC_DATA_W 16
`endif
